// *** rtl/ics_arbiter.sv ***
/*
 * interrupt recognition: compares the level code with the mask.
 * assumes level code and request are synchronous to mclk_in.
 */
`timescale 1ns/1ps
`include "ics_map.svh"

module ics_arbiter (
	input  wire logic [`ICS_LVL_W-1:0] interrupt_level_code_in,
	input  wire logic                  interrupt_request_n_in,
	input  wire logic [`ICS_LVL_W-1:0] mask_in,
	input  wire logic                  inhibit_in,
	output logic                       recognized_out
);

	// level 0 passes any mask; deasserted request never recognised
	always_comb begin
		recognized_out = !interrupt_request_n_in && !inhibit_in &&
			((interrupt_level_code_in <= mask_in) ||
			 (interrupt_level_code_in == `ICS_LVL_RESET));
	end

endmodule // ics_arbiter

// *** rtl/ics_core.sv ***
/*
 * interrupt recognition and workspace context switch sequencer.
 * assumes an instruction engine outside: it reports instruction
 * boundaries, requests branch/return/xop switches, and a memory that
 * answers each request with mem_ack_in; reads return data the same cycle.
 */
`timescale 1ns/1ps
`include "ics_map.svh"

// Overview of operation
// - words are two bytes, even byte addresses
// - sixteen bit addresses span 65536 bytes
// - lowest thirty-two words hold interrupt vectors
// - next thirty-two words hold xop vectors
// - load vector at top two words, reset vector at zero
// - program counter points past current instruction
// - workspace pointer marks first register word
// - register address is pointer plus twice number
// - entry uses two fetches, three stores; return three fetches
// - branch, return, xop, interrupt, reset, load switch
// - sixteen levels, zero highest and reset
// - recognise level not above status mask
// - switch starts after current instruction completes
// - fetch new pointer then new counter
// - old pointer, counter, status into 13-15
// - mask becomes level minus one, zero stays
// - no recognition until first handler instruction
// - higher level nests, return restores older context
// - level zero ignores the mask
// - code is binary level, vector at 4n
// - load input traps to top vector, mask zero
module ics_core (
	input  wire logic                   mclk_in,
	input  wire logic                   rst_in,
	input  wire logic [`ICS_LVL_W-1:0]  interrupt_level_code_in,
	input  wire logic                   interrupt_request_n_in,
	input  wire logic                   load_n_in,
	input  wire logic                   instr_done_in,
	input  wire logic                   pc_inc_in,
	input  wire logic                   branch_load_workspace_in,
	input  wire logic                   extended_operation_trap_in,
	input  wire logic [3:0]             xop_number_in,
	input  wire logic [`ICS_WORD_W-1:0] branch_load_workspace_vector_in,
	input  wire logic                   return_restore_context_in,
	input  wire logic [`ICS_WORD_W-1:0] status_in,
	input  wire logic                   status_wr_in,
	input  wire logic [3:0]             reg_num_in,
	input  wire logic [`ICS_WORD_W-1:0] mem_rdata_in,
	input  wire logic                   mem_ack_in,
	output logic [`ICS_ADDR_W-1:0]      mem_addr_out,
	output logic [`ICS_WORD_W-1:0]      mem_wdata_out,
	output logic                        mem_rd_out,
	output logic                        mem_wr_out,
	output logic [`ICS_WORD_W-1:0]      program_counter_out,
	output logic [`ICS_WORD_W-1:0]      workspace_ptr_out,
	output logic [`ICS_WORD_W-1:0]      status_word_out,
	output logic [`ICS_ADDR_W-1:0]      reg_addr_out,
	output logic                        switch_busy_out,
	output logic                        switch_done_out
);

	ics_pkg::ics_state_t           state_reg;
	ics_pkg::ics_state_t           state_next;
	ics_pkg::ics_src_t             src_reg;
	logic [`ICS_WORD_W-1:0]        program_counter_reg;
	logic [`ICS_WORD_W-1:0]        workspace_ptr_reg;
	logic [`ICS_WORD_W-1:0]        status_word_reg;
	logic [`ICS_WORD_W-1:0]        old_wp_reg;
	logic [`ICS_WORD_W-1:0]        old_pc_reg;
	logic [`ICS_WORD_W-1:0]        old_st_reg;
	logic [`ICS_ADDR_W-1:0]        vec_reg;
	logic [`ICS_LVL_W-1:0]         level_reg;
	logic                          inhibit_reg;
	logic                          reset_pend_reg;
	logic                          recognized;
	logic                          load_req;
	logic                          start_int;
	logic                          start_sw;
	logic                          step;
	logic [`ICS_LVL_W-1:0]         new_mask;
	logic [`ICS_ADDR_W-1:0]        int_vec;
	logic [`ICS_ADDR_W-1:0]        xop_vec;

	ics_arbiter u_arb (
		.interrupt_level_code_in (interrupt_level_code_in),
		.interrupt_request_n_in  (interrupt_request_n_in),
		.mask_in                 (status_word_reg[`ICS_MASK_HI:`ICS_MASK_LO]),
		.inhibit_in              (inhibit_reg),
		.recognized_out          (recognized)
	);

	assign load_req  = !load_n_in;
	// vector for level n sits at byte 4n inside the lowest 32 words
	assign int_vec   = {10'h000, interrupt_level_code_in, 2'b00};
	assign xop_vec   = `ICS_XOP_VEC_BASE + {10'h000, xop_number_in, 2'b00};
	// entries wait for an instruction boundary; reset needs none
	assign start_int = (state_reg == ics_pkg::ICS_IDLE) &&
		(reset_pend_reg || (instr_done_in && (recognized || load_req)));
	assign start_sw  = (state_reg == ics_pkg::ICS_IDLE) && !start_int &&
		(branch_load_workspace_in || extended_operation_trap_in ||
		 return_restore_context_in);
	assign step      = mem_ack_in;
	assign new_mask  = (level_reg == `ICS_LVL_RESET) ? `ICS_MASK_ZERO
		: level_reg - `ICS_LVL_ONE;

	// register address: pointer plus twice the register number
	assign reg_addr_out = workspace_ptr_reg + {11'h000, reg_num_in, 1'b0};

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ics_pkg::ICS_IDLE: begin
				if (start_int || (start_sw && !return_restore_context_in)) begin
					state_next = ics_pkg::ICS_FET_WP;
				end else if (start_sw) begin
					state_next = ics_pkg::ICS_RET_WP;
				end
			end
			ics_pkg::ICS_FET_WP: if (step) state_next = ics_pkg::ICS_FET_PC;
			ics_pkg::ICS_FET_PC: if (step) state_next = ics_pkg::ICS_STO_WP;
			ics_pkg::ICS_STO_WP: if (step) state_next = ics_pkg::ICS_STO_PC;
			ics_pkg::ICS_STO_PC: if (step) state_next = ics_pkg::ICS_STO_ST;
			ics_pkg::ICS_STO_ST: if (step) state_next = ics_pkg::ICS_DONE;
			ics_pkg::ICS_RET_WP: if (step) state_next = ics_pkg::ICS_RET_PC;
			ics_pkg::ICS_RET_PC: if (step) state_next = ics_pkg::ICS_RET_ST;
			ics_pkg::ICS_RET_ST: if (step) state_next = ics_pkg::ICS_DONE;
			ics_pkg::ICS_DONE:   state_next = ics_pkg::ICS_IDLE;
			default:             state_next = ics_pkg::ICS_IDLE;
		endcase
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			state_reg <= ics_pkg::ICS_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// source and vector captured when a switch starts; level only on interrupt, reset or load entry
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			src_reg   <= ics_pkg::ICS_SRC_INT;
			vec_reg   <= `ICS_PC_RESET;
			level_reg <= `ICS_LVL_RESET;
		end else if (start_int) begin
			src_reg <= ics_pkg::ICS_SRC_INT;
			if (reset_pend_reg) begin
				vec_reg   <= `ICS_PC_RESET;
				level_reg <= `ICS_LVL_RESET;
			end else if (recognized) begin
				vec_reg   <= int_vec;
				level_reg <= interrupt_level_code_in;
			end else begin
				src_reg   <= ics_pkg::ICS_SRC_LOAD;
				vec_reg   <= `ICS_LOAD_VEC;
				level_reg <= `ICS_LVL_RESET;
			end
		end else if (start_sw) begin
			src_reg <= extended_operation_trap_in ? ics_pkg::ICS_SRC_XOP
				: ics_pkg::ICS_SRC_BRANCH_LOAD_WORKSPACE;
			vec_reg <= extended_operation_trap_in ? xop_vec : branch_load_workspace_vector_in;
		end
	end

	// reset is serviced as a level 0 trap after its release
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			reset_pend_reg <= 1'b1;
		end else if (start_int) begin
			reset_pend_reg <= 1'b0;
		end
	end

	// old context latched at start; memory may be reused by the new one
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			old_wp_reg <= `ICS_WP_RESET;
			old_pc_reg <= `ICS_PC_RESET;
			old_st_reg <= `ICS_ST_RESET;
		end else if (start_int || start_sw) begin
			old_wp_reg <= workspace_ptr_reg;
			old_pc_reg <= program_counter_reg;
			old_st_reg <= status_word_reg;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			workspace_ptr_reg <= `ICS_WP_RESET;
		end else if (step && ((state_reg == ics_pkg::ICS_FET_WP) ||
				(state_reg == ics_pkg::ICS_RET_WP))) begin
			workspace_ptr_reg <= {mem_rdata_in[`ICS_WORD_W-1:1], 1'b0};
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			program_counter_reg <= `ICS_PC_RESET;
		end else if (step && ((state_reg == ics_pkg::ICS_FET_PC) ||
				(state_reg == ics_pkg::ICS_RET_PC))) begin
			// odd byte bit dropped so a bad vector cannot misalign fetches
			program_counter_reg <= {mem_rdata_in[`ICS_WORD_W-1:1], 1'b0};
		end else if (pc_inc_in && (state_reg == ics_pkg::ICS_IDLE)) begin
			program_counter_reg <= program_counter_reg + `ICS_WORD_STEP;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			status_word_reg <= `ICS_ST_RESET;
		end else if (step && (state_reg == ics_pkg::ICS_RET_ST)) begin
			status_word_reg <= mem_rdata_in;
		end else if (step && (state_reg == ics_pkg::ICS_STO_ST) &&
				(src_reg == ics_pkg::ICS_SRC_INT || src_reg == ics_pkg::ICS_SRC_LOAD)) begin
			status_word_reg[`ICS_MASK_HI:`ICS_MASK_LO] <= new_mask;
		end else if (status_wr_in && (state_reg == ics_pkg::ICS_IDLE)) begin
			status_word_reg <= status_in;
		end
	end

	// hold off recognition until the first handler instruction ends
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			inhibit_reg <= 1'b1;
		end else if (state_reg != ics_pkg::ICS_IDLE || start_int || start_sw) begin
			inhibit_reg <= 1'b1;
		end else if (instr_done_in) begin
			inhibit_reg <= 1'b0;
		end
	end

	// entry: two vector fetches and three saves; return: three fetches
	always_comb begin
		mem_addr_out  = vec_reg;
		mem_wdata_out = old_wp_reg;
		mem_rd_out    = 1'b0;
		mem_wr_out    = 1'b0;
		unique case (state_reg)
			ics_pkg::ICS_FET_WP: begin
				mem_rd_out = 1'b1;
			end
			ics_pkg::ICS_FET_PC: begin
				mem_addr_out = vec_reg + `ICS_WORD_STEP;
				mem_rd_out   = 1'b1;
			end
			ics_pkg::ICS_STO_WP: begin
				mem_addr_out = workspace_ptr_reg + {11'h000, `ICS_REG_OLD_WP, 1'b0};
				mem_wr_out   = 1'b1;
			end
			ics_pkg::ICS_STO_PC: begin
				mem_addr_out  = workspace_ptr_reg + {11'h000, `ICS_REG_OLD_PC, 1'b0};
				mem_wdata_out = old_pc_reg;
				mem_wr_out    = 1'b1;
			end
			ics_pkg::ICS_STO_ST: begin
				mem_addr_out  = workspace_ptr_reg + {11'h000, `ICS_REG_OLD_ST, 1'b0};
				mem_wdata_out = old_st_reg;
				mem_wr_out    = 1'b1;
			end
			ics_pkg::ICS_RET_WP: begin
				mem_addr_out = old_wp_reg + {11'h000, `ICS_REG_OLD_WP, 1'b0};
				mem_rd_out   = 1'b1;
			end
			ics_pkg::ICS_RET_PC: begin
				mem_addr_out = old_wp_reg + {11'h000, `ICS_REG_OLD_PC, 1'b0};
				mem_rd_out   = 1'b1;
			end
			ics_pkg::ICS_RET_ST: begin
				mem_addr_out = old_wp_reg + {11'h000, `ICS_REG_OLD_ST, 1'b0};
				mem_rd_out   = 1'b1;
			end
			ics_pkg::ICS_IDLE, ics_pkg::ICS_DONE: begin
				mem_addr_out = vec_reg;
			end
			default: begin
				mem_addr_out = vec_reg;
			end
		endcase
	end

	assign program_counter_out = program_counter_reg;
	assign workspace_ptr_out   = workspace_ptr_reg;
	assign status_word_out     = status_word_reg;
	assign switch_busy_out     = (state_reg != ics_pkg::ICS_IDLE);
	assign switch_done_out     = (state_reg == ics_pkg::ICS_DONE);

	// assertions
	property p_fetch_then_pc;
		@(posedge mclk_in) disable iff (rst_in)
		(state_reg == ics_pkg::ICS_FET_WP && step) |=> (state_reg == ics_pkg::ICS_FET_PC);
	endproperty
	a_fetch_then_pc: assert property (p_fetch_then_pc) else $error("pc fetch not after wp");

	property p_no_mid_instr;
		@(posedge mclk_in) disable iff (rst_in)
		($rose(switch_busy_out) && !$past(reset_pend_reg)) |->
			$past(instr_done_in) || $past(start_sw);
	endproperty
	a_no_mid_instr: assert property (p_no_mid_instr) else $error("switch mid instruction");

	property p_mask_set;
		@(posedge mclk_in) disable iff (rst_in)
		(state_reg == ics_pkg::ICS_STO_ST && step && src_reg == ics_pkg::ICS_SRC_INT) |=>
			status_word_reg[`ICS_MASK_HI:`ICS_MASK_LO] == $past(new_mask);
	endproperty
	a_mask_set: assert property (p_mask_set) else $error("mask not level minus one");

	property p_store_r13;
		@(posedge mclk_in) disable iff (rst_in)
		(state_reg == ics_pkg::ICS_STO_WP) |->
			mem_wr_out && mem_addr_out == workspace_ptr_reg + 16'h001A && mem_wdata_out == old_wp_reg;
	endproperty
	a_store_r13: assert property (p_store_r13) else $error("old wp not to r13");

	property p_lvl0;
		@(posedge mclk_in) disable iff (rst_in)
		(!interrupt_request_n_in && interrupt_level_code_in == `ICS_LVL_RESET && !inhibit_reg)
			|-> recognized;
	endproperty
	a_lvl0: assert property (p_lvl0) else $error("level zero masked");

	property p_no_req;
		@(posedge mclk_in) disable iff (rst_in)
		interrupt_request_n_in |-> !recognized;
	endproperty
	a_no_req: assert property (p_no_req) else $error("recognised without request");

	property p_inhibit;
		@(posedge mclk_in) disable iff (rst_in)
		switch_done_out |=> inhibit_reg;
	endproperty
	a_inhibit: assert property (p_inhibit) else $error("no inhibit after switch");

	property p_load_vec;
		@(posedge mclk_in) disable iff (rst_in)
		(state_reg == ics_pkg::ICS_FET_WP && src_reg == ics_pkg::ICS_SRC_LOAD) |->
			mem_addr_out == `ICS_LOAD_VEC;
	endproperty
	a_load_vec: assert property (p_load_vec) else $error("load vector wrong");

	c_int:  cover property (@(posedge mclk_in) start_int && recognized);
	c_ret:  cover property (@(posedge mclk_in) state_reg == ics_pkg::ICS_RET_ST && step);
	c_load: cover property (@(posedge mclk_in) src_reg == ics_pkg::ICS_SRC_LOAD && switch_done_out);

endmodule // ics_core

// *** shared/ics_map.svh ***
/*
 * constants for the interrupt and context switch unit: memory layout,
 * vector addresses, workspace register numbers and status fields.
 * assumes inclusion by bare name from rtl/ and the package file.
 */
`ifndef ICS_MAP_SVH
`define ICS_MAP_SVH

`define ICS_WORD_W        16
`define ICS_BYTE_W        8
`define ICS_ADDR_W        16
`define ICS_MEM_BYTES     32'd65536
`define ICS_MEM_WORDS     32'd32768
`define ICS_LEVELS        16
`define ICS_LVL_W         4
`define ICS_INT_VEC_WORDS 16'h0020
`define ICS_XOP_VEC_BASE  16'h0040
`define ICS_XOP_VEC_WORDS 16'h0020
`define ICS_LOAD_VEC      16'hFFFC
`define ICS_LOAD_VEC_PC   16'hFFFE
`define ICS_WS_WORDS      5'h10
`define ICS_REG_OLD_WP    4'hD
`define ICS_REG_OLD_PC    4'hE
`define ICS_REG_OLD_ST    4'hF
`define ICS_MASK_HI       15
`define ICS_MASK_LO       12
`define ICS_MASK_ZERO     4'h0
`define ICS_LVL_RESET     4'h0
`define ICS_LVL_ONE       4'h1
`define ICS_WORD_STEP     16'h0002
`define ICS_PC_RESET      16'h0000
`define ICS_WP_RESET      16'h0000
`define ICS_ST_RESET      16'h0000

`endif

// *** shared/ics_pkg.sv ***
/*
 * types for the interrupt and context switch unit.
 * assumes the map header is on the include path.
 */
`include "ics_map.svh"

package ics_pkg;

	typedef enum logic [3:0] {
		ICS_IDLE    = 4'h0,
		ICS_FET_WP  = 4'h1,
		ICS_FET_PC  = 4'h2,
		ICS_STO_WP  = 4'h3,
		ICS_STO_PC  = 4'h4,
		ICS_STO_ST  = 4'h5,
		ICS_RET_WP  = 4'h6,
		ICS_RET_PC  = 4'h7,
		ICS_RET_ST  = 4'h8,
		ICS_DONE    = 4'h9
	} ics_state_t;

	typedef enum logic [1:0] {
		ICS_SRC_INT  = 2'h0,
		ICS_SRC_LOAD = 2'h1,
		ICS_SRC_BRANCH_LOAD_WORKSPACE = 2'h2,
		ICS_SRC_XOP  = 2'h3
	} ics_src_t;

endpackage

// *** verification/ics_far_side.sv ***
/*
 * far side model: word memory answering the switch bus, and a priority
 * encoder for sixteen request lines. assumes one clock shared with the core.
 */
`timescale 1ns/1ps

module ics_far_side (
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic [15:0] addr_in,
	input  wire logic [15:0] wdata_in,
	input  wire logic        rd_in,
	input  wire logic        wr_in,
	input  wire logic [3:0]  delay_in,
	input  wire logic [15:0] lines_in,
	output logic      [15:0] rdata_out,
	output logic             ack_out,
	output logic      [3:0]  code_out,
	output logic             req_n_out
);
	logic [15:0] mem_words [0:32767];
	logic [3:0]  wait_reg;

	// data not being answered is flipped so a stale read never matches
	always @(posedge clk_in) begin
		if (rst_in || ack_out) begin
			ack_out <= 1'b0;
			wait_reg <= 4'h0;
			rdata_out <= ~rdata_out;
		end else if ((rd_in || wr_in) && wait_reg == delay_in) begin
			ack_out <= 1'b1;
			if (wr_in)
				mem_words[addr_in[15:1]] <= wdata_in;
			else
				rdata_out <= mem_words[addr_in[15:1]];
		end else if (rd_in || wr_in) begin
			wait_reg <= wait_reg + 4'h1;
		end
	end

	// lowest set line wins; a lone source could tie the code instead
	always_comb begin
		code_out = 4'h0;
		for (int i = 15; i >= 0; i--)
			if (lines_in[i]) code_out = i[3:0];
	end
	assign req_n_out = ~|lines_in;
endmodule // ics_far_side

// *** verification/interrupt_context_switch_tb.sv ***
/*
 * bench for the context switch core: drives instruction events at the
 * falling edge. assumes the far side model answers the memory bus.
 */
`timescale 1ns/1ps
`include "ics_map.svh"
`define ICS_CHECK(got, exp) begin tests_run++; if ((got) !== (exp)) begin bad_count++; \
	$display("wrong value at %0t: got %h expected %h", $time, got, exp); end end

module interrupt_context_switch_tb;
	logic mclk_in = 0, rst_in = 1, load_n_in = 1, instr_done_in = 0, pc_inc_in = 0;
	logic branch_load_workspace_in = 0, extended_operation_trap_in = 0;
	logic return_restore_context_in = 0, status_wr_in = 0, mem_ack_in, interrupt_request_n_in;
	logic [3:0]  xop_number_in = 0, reg_num_in = 0, dly = 0, interrupt_level_code_in;
	logic [15:0] branch_load_workspace_vector_in = 0, status_in = 0, lines = 0, mem_rdata_in;
	logic [15:0] mem_addr_out, mem_wdata_out, program_counter_out, workspace_ptr_out;
	logic [15:0] status_word_out, reg_addr_out, e_wp = 0, e_pc = 0, e_st = 0;
	logic        mem_rd_out, mem_wr_out, switch_busy_out, switch_done_out, saw;
	logic [15:0] q_a[$], q_d[$], s_wp[$], s_pc[$], s_st[$];
	logic        q_w[$];
	int          bad_count = 0, tests_run = 0;

	ics_core i_dut (.mclk_in, .rst_in, .interrupt_level_code_in, .interrupt_request_n_in,
		.load_n_in, .instr_done_in, .pc_inc_in, .branch_load_workspace_in,
		.extended_operation_trap_in, .xop_number_in, .branch_load_workspace_vector_in,
		.return_restore_context_in, .status_in, .status_wr_in, .reg_num_in, .mem_rdata_in,
		.mem_ack_in, .mem_addr_out, .mem_wdata_out, .mem_rd_out, .mem_wr_out,
		.program_counter_out, .workspace_ptr_out, .status_word_out, .reg_addr_out,
		.switch_busy_out, .switch_done_out);
	ics_far_side i_far (.clk_in(mclk_in), .rst_in(rst_in), .addr_in(mem_addr_out),
		.wdata_in(mem_wdata_out), .rd_in(mem_rd_out), .wr_in(mem_wr_out), .delay_in(dly),
		.lines_in(lines), .rdata_out(mem_rdata_in), .ack_out(mem_ack_in),
		.code_out(interrupt_level_code_in), .req_n_out(interrupt_request_n_in));

	initial forever #2.5 mclk_in = ~mclk_in;

	always @(posedge mclk_in) if (mem_ack_in && (mem_rd_out || mem_wr_out)) begin
		q_a.push_back(mem_addr_out);
		q_d.push_back(mem_wr_out ? mem_wdata_out : mem_rdata_in);
		q_w.push_back(mem_wr_out);
	end

	// vectors give distinct, spread out workspaces so none overlaps a vector
	function automatic logic [15:0] f_wp(input logic [15:0] v);
		return 16'h1000 + {v[11:0], 4'h0};
	endfunction
	function automatic logic [15:0] f_pc(input logic [15:0] v);
		return 16'h8000 ^ v;
	endfunction

	task automatic end_sim;
		$display("compares %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic put(input logic [15:0] v);
		i_far.mem_words[v[15:1]] = f_wp(v);
		i_far.mem_words[v[15:1] + 15'h1] = f_pc(v);
	endtask
	task automatic clr;
		q_a.delete();
		q_d.delete();
		q_w.delete();
	endtask
	task automatic pulse(ref logic s);
		clr();
		@(negedge mclk_in) s = 1;
		@(negedge mclk_in) s = 0;
	endtask
	task automatic setst(input logic [15:0] v);
		status_in = v;
		pulse(status_wr_in);
		e_st = v;
	endtask
	// two instruction ends, so the one after a switch is covered as well
	task automatic step;
		clr();
		saw = 0;
		repeat (2) begin
			@(negedge mclk_in) instr_done_in = 1;
			@(negedge mclk_in) instr_done_in = 0;
			saw |= switch_busy_out;
		end
	endtask
	task automatic wait_done;
		int k;
		for (k = 0; k < 80 && switch_done_out !== 1'b1; k++) @(negedge mclk_in);
		if (k == 80) begin
			bad_count++;
			end_sim();
		end
	endtask

	task automatic enter(input logic [15:0] v, input logic [3:0] m);
		logic [15:0] nw;
		nw = f_wp(v);
		wait_done();
		`ICS_CHECK(q_a.size(), 5)
		if (q_a.size() == 5) begin
			`ICS_CHECK({q_w[0], q_w[1], q_a[0], q_a[1]}, {2'b00, v, v + 16'h2})
			`ICS_CHECK({q_w[2], q_a[2], q_d[2]}, {1'b1, nw + 16'h1A, e_wp})
			`ICS_CHECK({q_a[3], q_d[3], q_a[4], q_d[4]}, {nw + 16'h1C, e_pc, nw + 16'h1E, e_st})
		end
		s_wp.push_back(e_wp);
		s_pc.push_back(e_pc);
		s_st.push_back(e_st);
		e_wp = nw;
		e_pc = f_pc(v);
		e_st = {m, e_st[11:0]};
		@(negedge mclk_in);
		`ICS_CHECK({workspace_ptr_out, program_counter_out}, {e_wp, e_pc})
		`ICS_CHECK(status_word_out[`ICS_MASK_HI:`ICS_MASK_LO], m)
	endtask

	task automatic leave;
		logic [15:0] w;
		w = e_wp;
		pulse(return_restore_context_in);
		wait_done();
		e_wp = s_wp.pop_back();
		e_pc = s_pc.pop_back();
		e_st = s_st.pop_back();
		`ICS_CHECK(q_a.size(), 3)
		if (q_a.size() == 3) begin
			`ICS_CHECK({q_w[0], q_w[1], q_w[2]}, 3'b000)
			`ICS_CHECK({q_a[0], q_a[1], q_a[2]}, {w + 16'h1A, w + 16'h1C, w + 16'h1E})
		end
		@(negedge mclk_in);
		`ICS_CHECK({workspace_ptr_out, program_counter_out}, {e_wp, e_pc})
		`ICS_CHECK(status_word_out, e_st)
	endtask

	initial begin
		for (int v = 0; v < 128; v += 4) put(v[15:0]);
		put(16'h0200);
		put(16'hFFFC);
		repeat (12) @(negedge mclk_in);
		rst_in = 0;
		enter(16'h0000, 4'h0);
		reg_num_in = 4'h7;
		pulse(pc_inc_in);
		`ICS_CHECK(program_counter_out, e_pc + 16'h2)
		`ICS_CHECK(reg_addr_out, e_wp + 16'h000E)
		e_pc = e_pc + 16'h2;
		$display("test reset entry and registers done");
		for (int n = 1; n < 16; n++) begin
			dly = {2'b00, n[1:0]};
			setst(16'hF000);
			lines[n] = 1'b1;
			step();
			enter({n[13:0], 2'b00}, n[3:0] - 4'h1);
			lines[n] = 1'b0;
		end
		$display("test all levels done");
		setst(16'h1000);
		lines[2] = 1'b1;
		step();
		`ICS_CHECK(saw, 1'b0)
		lines = 16'h0000;
		step();
		`ICS_CHECK(saw, 1'b0)
		$display("test masked and idle requests done");
		setst(16'hF000);
		lines[5] = 1'b1;
		repeat (8) @(negedge mclk_in);
		`ICS_CHECK(switch_busy_out, 1'b0)
		step();
		enter(16'h0014, 4'h4);
		lines[4] = 1'b1;
		pulse(instr_done_in);
		`ICS_CHECK(switch_busy_out, 1'b0)
		step();
		enter(16'h0010, 4'h3);
		lines = 16'h0000;
		leave();
		$display("test nesting done");
		lines[0] = 1'b1;
		step();
		enter(16'h0000, 4'h0);
		lines = 16'h0000;
		load_n_in = 0;
		step();
		load_n_in = 1;
		enter(16'hFFFC, 4'h0);
		$display("test level zero and load done");
		dly = 4'h3;
		branch_load_workspace_vector_in = 16'h0200;
		pulse(branch_load_workspace_in);
		enter(16'h0200, e_st[15:12]);
		xop_number_in = 4'h3;
		pulse(extended_operation_trap_in);
		enter(16'h004C, e_st[15:12]);
		leave();
		$display("test branch, xop and return done");
		end_sim();
	end
endmodule // interrupt_context_switch_tb
